// ---- src/tmoc_top.v ----
// Purpose: mode and output control slice of a 16-bit timer channel
// Assumes: counter core, prescaler and edge registers sit outside;
//          they reach this slice through ticks, waveforms and edge selects
// Notes:   all outputs registered; registers clear on any reset
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "tmoc_regs.vh"

module tmoc_top #(
  parameter NUM_PINS = 2
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [`TMOC_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_prescale_tick,
  input wire i_master_run,
  input wire i_timer_input_zero,
  input wire [1:0] i_event_edge_sel,
  input wire [1:0] i_trig_edge_sel,
  input wire [NUM_PINS-1:0] i_timer_wave,
  output wire [NUM_PINS-1:0] o_timer_pulse_pin,
  output reg o_channel_rst_n,
  output reg o_clock_run,
  output reg o_count_tick,
  output reg o_trigger,
  output reg [2:0] o_mode,
  output reg o_mode_error,
  output reg [2:0] o_prescale_select,
  output reg o_slave_mode
);

  // reset release
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // pin input synchroniser
  reg pin_meta_ff;
  reg pin_sync_ff;

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= i_timer_input_zero;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // reset images of the registers
  localparam [7:0] RUN_CTL_RST = `TMOC_RUN_CTL_RST;
  localparam [7:0] MODE_CTL_RST = `TMOC_MODE_CTL_RST;
  localparam [7:0] OUT_CTL_RST = `TMOC_OUT_CTL_RST;

  // registers
  reg run_en_ff;
  reg [2:0] prescale_ff;
  reg slave_ff;
  reg clk_src_ff;
  reg [2:0] mode_ff;
  reg [NUM_PINS-1:0] out_en_ff;
  reg [NUM_PINS-1:0] out_inv_ff;

  wire sel_run;
  wire sel_mode;
  wire sel_out;
  wire wr_run;
  wire wr_mode;
  wire wr_out;

  assign sel_run = (i_addr == `TMOC_ADDR_RUN_CTL);
  assign sel_mode = (i_addr == `TMOC_ADDR_MODE_CTL);
  assign sel_out = (i_addr == `TMOC_ADDR_OUT_CTL);
  assign wr_run = i_wr & sel_run;
  assign wr_mode = i_wr & sel_mode;
  assign wr_out = i_wr & sel_out;

  function is_trig_mode;
    input [2:0] mode;
    begin
      is_trig_mode = (mode == `TMOC_MODE_EXT_TRIG) || (mode == `TMOC_MODE_ONE_SHOT);
    end
  endfunction

  // run enable cannot be raised while slave bit is set
  reg nxt_run_en;

  always @* begin
    nxt_run_en = run_en_ff;
    if (wr_run) begin
      nxt_run_en = i_wdata[`TMOC_RUN_EN_BIT] & ~slave_ff;
    end
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_en_ff <= RUN_CTL_RST[`TMOC_RUN_EN_BIT];
      prescale_ff <= RUN_CTL_RST[`TMOC_PRESCALE_MSB:`TMOC_PRESCALE_LSB];
    end else begin
      run_en_ff <= nxt_run_en;
      if (wr_run) begin
        prescale_ff <= i_wdata[`TMOC_PRESCALE_MSB:`TMOC_PRESCALE_LSB];
      end
    end
  end

  // mode control; bits 6, 4 and 3 not stored
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      slave_ff <= MODE_CTL_RST[`TMOC_SLAVE_BIT];
      clk_src_ff <= MODE_CTL_RST[`TMOC_CLK_SRC_BIT];
      mode_ff <= MODE_CTL_RST[`TMOC_MODE_MSB:`TMOC_MODE_LSB];
    end else if (wr_mode) begin
      slave_ff <= i_wdata[`TMOC_SLAVE_BIT];
      clk_src_ff <= i_wdata[`TMOC_CLK_SRC_BIT];
      mode_ff <= i_wdata[`TMOC_MODE_MSB:`TMOC_MODE_LSB];
    end
  end

  // output control; bits 7 to 4 not stored
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_ff <= {OUT_CTL_RST[`TMOC_OUT_EN1_BIT], OUT_CTL_RST[`TMOC_OUT_EN0_BIT]};
      out_inv_ff <= {OUT_CTL_RST[`TMOC_OUT_INV1_BIT], OUT_CTL_RST[`TMOC_OUT_INV0_BIT]};
    end else if (wr_out) begin
      out_en_ff <= {i_wdata[`TMOC_OUT_EN1_BIT], i_wdata[`TMOC_OUT_EN0_BIT]};
      out_inv_ff <= {i_wdata[`TMOC_OUT_INV1_BIT], i_wdata[`TMOC_OUT_INV0_BIT]};
    end
  end

  // read data, one cycle after the read strobe
  // unused bits tie low; soft trigger bit reads zero
  wire [7:0] run_ctl_rd;
  wire [7:0] mode_ctl_rd;
  wire [7:0] out_ctl_rd;
  reg [7:0] nxt_rdata;

  assign run_ctl_rd = {run_en_ff, 4'h0, prescale_ff};
  assign mode_ctl_rd = {slave_ff, 1'b0, clk_src_ff, 2'h0, mode_ff};
  assign out_ctl_rd = {4'h0, out_inv_ff[1], out_en_ff[1], out_inv_ff[0], out_en_ff[0]};

  always @* begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      if (sel_run) begin
        nxt_rdata = run_ctl_rd;
      end else if (sel_mode) begin
        nxt_rdata = mode_ctl_rd;
      end else if (sel_out) begin
        nxt_rdata = out_ctl_rd;
      end
    end
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= nxt_rdata;
    end
  end

  // clock start pipeline: clock runs two cycles after run enable rises
  reg [`TMOC_START_CYCLES-2:0] start_pipe_ff;
  reg nxt_clock_run;
  wire [`TMOC_START_CYCLES-1:0] start_shift;

  assign start_shift = {start_pipe_ff, run_en_ff};

  always @* begin
    if (slave_ff) begin
      nxt_clock_run = i_master_run;
    end else begin
      nxt_clock_run = start_pipe_ff[`TMOC_START_CYCLES-2];
    end
    if (!nxt_run_en && !slave_ff) begin
      nxt_clock_run = 1'b0;
    end
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_pipe_ff <= {(`TMOC_START_CYCLES-1){1'b0}};
      o_clock_run <= 1'b0;
      o_channel_rst_n <= 1'b0;
    end else begin
      if (!nxt_run_en) begin
        start_pipe_ff <= {(`TMOC_START_CYCLES-1){1'b0}};
      end else begin
        start_pipe_ff <= start_shift[`TMOC_START_CYCLES-2:0];
      end
      o_clock_run <= nxt_clock_run;
      o_channel_rst_n <= nxt_run_en | slave_ff;
    end
  end

  // edge detection on input zero
  wire event_edge;
  wire trig_edge;

  tmoc_edge_det u_event_edge (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_level(pin_sync_ff),
    .i_edge_sel(i_event_edge_sel),
    .o_edge(event_edge)
  );

  tmoc_edge_det u_trig_edge (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_level(pin_sync_ff),
    .i_edge_sel(i_trig_edge_sel),
    .o_edge(trig_edge)
  );

  // count source and triggers
  wire use_ext_clock;
  wire count_src;
  wire soft_trig;
  wire hw_trig;

  assign use_ext_clock = clk_src_ff | (mode_ff == `TMOC_MODE_EVENT);
  assign count_src = use_ext_clock ? event_edge : i_prescale_tick;
  // soft trigger acts on the run enable bit, not on the started clock
  assign soft_trig = wr_mode & i_wdata[`TMOC_SOFT_TRIG_BIT] & run_en_ff
    & is_trig_mode(mode_ff);
  // pin trigger waits until the count clock really runs
  assign hw_trig = trig_edge & o_clock_run & is_trig_mode(mode_ff);

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_count_tick <= 1'b0;
      o_trigger <= 1'b0;
      o_mode <= `TMOC_MODE_INTERVAL;
      o_mode_error <= 1'b0;
      o_prescale_select <= 3'h0;
      o_slave_mode <= 1'b0;
    end else begin
      o_count_tick <= nxt_clock_run & count_src;
      o_trigger <= soft_trig | hw_trig;
      // prohibited mode is kept as written and only flagged
      o_mode <= mode_ff;
      o_mode_error <= (mode_ff == `TMOC_MODE_PROHIBITED);
      o_prescale_select <= prescale_ff;
      o_slave_mode <= slave_ff;
    end
  end

  // output pins
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      tmoc_pin_drive u_pin (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_wave(i_timer_wave[gi]),
        .i_invert(out_inv_ff[gi]),
        .i_enable(out_en_ff[gi]),
        .o_pin(o_timer_pulse_pin[gi])
      );
    end
  endgenerate

endmodule

// ---- src/tmoc_regs.vh ----
// Purpose: register map, field positions, reset values and codes of the
//          timer mode and output control slice
// Assumes: byte-wide register port, addresses as printed
// Notes:   definitions only
`ifndef TMOC_REGS_VH
`define TMOC_REGS_VH

`define TMOC_ADDR_W 28
`define TMOC_ADDR_RUN_CTL 28'hfff_f590
`define TMOC_ADDR_MODE_CTL 28'hfff_f591
`define TMOC_ADDR_OUT_CTL 28'hfff_f592

`define TMOC_RUN_CTL_RST 8'h00
`define TMOC_MODE_CTL_RST 8'h00
`define TMOC_OUT_CTL_RST 8'h00

`define TMOC_RUN_EN_BIT 7
`define TMOC_PRESCALE_LSB 0
`define TMOC_PRESCALE_MSB 2

`define TMOC_SLAVE_BIT 7
`define TMOC_SOFT_TRIG_BIT 6
`define TMOC_CLK_SRC_BIT 5
`define TMOC_MODE_LSB 0
`define TMOC_MODE_MSB 2

`define TMOC_OUT_EN0_BIT 0
`define TMOC_OUT_INV0_BIT 1
`define TMOC_OUT_EN1_BIT 2
`define TMOC_OUT_INV1_BIT 3

`define TMOC_MODE_INTERVAL 3'h0
`define TMOC_MODE_EVENT 3'h1
`define TMOC_MODE_EXT_TRIG 3'h2
`define TMOC_MODE_ONE_SHOT 3'h3
`define TMOC_MODE_PWM 3'h4
`define TMOC_MODE_FREE_RUN 3'h5
`define TMOC_MODE_PULSE_MEAS 3'h6
`define TMOC_MODE_PROHIBITED 3'h7

`define TMOC_EDGE_NONE 2'h0
`define TMOC_EDGE_RISE 2'h1
`define TMOC_EDGE_FALL 2'h2
`define TMOC_EDGE_BOTH 2'h3

`define TMOC_START_CYCLES 2

`endif

// ---- src/tmoc_edge_det.v ----
// Purpose: valid-edge detector on an already synchronised level
// Assumes: i_level is in the i_mclk domain
// Notes:   o_edge is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
`include "tmoc_regs.vh"

module tmoc_edge_det (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_level,
  input wire [1:0] i_edge_sel,
  output reg o_edge
);

  reg level_prev_ff;

  function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      case (sel)
        `TMOC_EDGE_RISE: edge_hit = cur & ~prev;
        `TMOC_EDGE_FALL: edge_hit = ~cur & prev;
        `TMOC_EDGE_BOTH: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_prev_ff <= 1'b0;
      o_edge <= 1'b0;
    end else begin
      level_prev_ff <= i_level;
      o_edge <= edge_hit(i_edge_sel, i_level, level_prev_ff);
    end
  end

endmodule

// ---- src/tmoc_pin_drive.v ----
// Purpose: one timer output pin with invert and enable
// Assumes: i_wave comes from the counter core on the same clock
// Notes:   pin is low after reset
`timescale 1ns/100ps

module tmoc_pin_drive (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_wave,
  input wire i_invert,
  input wire i_enable,
  output reg o_pin
);

  wire nxt_pin;

  // disabled pin rests at its invert level
  assign nxt_pin = i_enable ? (i_wave ^ i_invert) : i_invert;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= nxt_pin;
    end
  end

endmodule

// ---- tb/tmoc_pin_far.sv ----
// Purpose: far-side model of the timer input pin
// Assumes: bench pulses i_step one cycle per wanted level change
// Notes: pin idles low and moves only on request
`timescale 1ns/100ps
module tmoc_pin_far (
  input wire i_mclk,
  input wire i_step,
  output logic o_tin
);
  initial o_tin = 1'b0;
  always @(posedge i_mclk) begin
    if (i_step) o_tin <= ~o_tin;
  end
endmodule

// ---- tb/tmoc_top_props.sv ----
// Purpose: port-level assertions for tmoc_top
// Assumes: bound into every tmoc_top instance
// Notes: shadows mirror output register and slave bit writes
`timescale 1ns/100ps
`include "tmoc_regs.vh"
module tmoc_top_props #(
  parameter NUM_PINS = 2
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [`TMOC_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_master_run,
  input wire [NUM_PINS-1:0] i_timer_wave,
  input wire [NUM_PINS-1:0] o_timer_pulse_pin,
  input wire o_channel_rst_n,
  input wire o_clock_run,
  input wire o_trigger,
  input wire [2:0] o_mode,
  input wire o_mode_error,
  input wire o_slave_mode
);
  reg [3:0] out_sh_ff;
  reg [7:0] wd_ff;
  reg [7:0] wd2_ff;
  reg slv_sh_ff;
  wire [1:0] exp_pin;
  wire wr_run = i_wr && i_addr == `TMOC_ADDR_RUN_CTL;
  wire wr_mode = i_wr && i_addr == `TMOC_ADDR_MODE_CTL;
  assign exp_pin[0] = out_sh_ff[0] ? i_timer_wave[0] ^ out_sh_ff[1] : out_sh_ff[1];
  assign exp_pin[1] = out_sh_ff[2] ? i_timer_wave[1] ^ out_sh_ff[3] : out_sh_ff[3];
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_sh_ff <= 4'h0;
      wd_ff <= 8'h00;
      wd2_ff <= 8'h00;
      slv_sh_ff <= 1'b0;
    end else begin
      wd_ff <= i_wdata;
      wd2_ff <= wd_ff;
      if (wr_mode) slv_sh_ff <= i_wdata[7];
      if (i_wr && i_addr == `TMOC_ADDR_OUT_CTL) out_sh_ff <= i_wdata[3:0];
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence run_up;
    o_channel_rst_n ##2 o_clock_run;
  endsequence
  sequence soft_req;
    wr_mode && i_wdata[6] && i_wdata[2:1] == 2'b01 && o_mode == i_wdata[2:0]
      && o_clock_run && !slv_sh_ff;
  endsequence
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  mode_read_a: assert property (i_rd && i_addr == `TMOC_ADDR_MODE_CTL
    |=> (o_rdata & 8'h58) == 8'h00) else $error("mode reg fixed bits set");
  out_read_a: assert property (i_rd && i_addr == `TMOC_ADDR_OUT_CTL
    |=> o_rdata[7:4] == 4'h0) else $error("output reg upper bits set");
  mode_load_a: assert property (wr_mode |-> ##2 o_mode == wd2_ff[2:0]
    && o_slave_mode == wd2_ff[7] && o_mode_error == (wd2_ff[2:0] == 3'h7))
    else $error("mode fields not loaded");
  run_start_a: assert property (wr_run && i_wdata[7] && !slv_sh_ff |=> run_up)
    else $error("run start late");
  run_stop_a: assert property (wr_run && !i_wdata[7] && !slv_sh_ff
    |=> !o_clock_run && !o_channel_rst_n) else $error("run stop late");
  slave_follow_a: assert property (slv_sh_ff |=> o_clock_run == $past(i_master_run))
    else $error("slave clock not following master");
  soft_trig_a: assert property (soft_req |=> o_trigger)
    else $error("soft trigger missing");
  trig_mode_a: assert property (o_trigger |-> o_mode[2:1] == 2'b01 && $past(o_channel_rst_n))
    else $error("trigger outside triggered modes");
  pin_level_a: assert property (1'b1 |=> o_timer_pulse_pin[1:0] == $past(exp_pin))
    else $error("pin level wrong");
endmodule
bind tmoc_top tmoc_top_props #(.NUM_PINS(NUM_PINS)) u_tmoc_top_props (.i_mclk, .i_rst_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_master_run, .i_timer_wave,
  .o_timer_pulse_pin, .o_channel_rst_n, .o_clock_run, .o_trigger, .o_mode,
  .o_mode_error, .o_slave_mode);

// ---- tb/tmoc_top_tb.sv ----
// Purpose: self-checking bench for tmoc_top
// Assumes: input pin driven through tmoc_pin_far
// Notes: fixed seed, corner cases mixed with random
`timescale 1ns/100ps
`include "tmoc_regs.vh"
module tmoc_top_tb;
  localparam RA = `TMOC_ADDR_RUN_CTL;
  localparam MA = `TMOC_ADDR_MODE_CTL;
  localparam OA = `TMOC_ADDR_OUT_CTL;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, tick = 0, mrun = 0, tog = 0;
  logic [27:0] addr = 0;
  logic [7:0] wd = 0, o, rdata;
  logic [7:0] cfg [3] = '{8'h01, 8'h02, 8'h20};
  logic [1:0] ees = 0, tes = 0, wave = 0, pins;
  logic [2:0] mode, psel;
  logic crst, crun, ctick, trig, merr, slv, tin;
  int err_total = 0, num_checks = 0, ticks = 0, trigs = 0, t0, g0, n, b;
  tmoc_top #(.NUM_PINS(2)) u_tmoc_top (.i_mclk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_prescale_tick(tick),
    .i_master_run(mrun), .i_timer_input_zero(tin), .i_event_edge_sel(ees),
    .i_trig_edge_sel(tes), .i_timer_wave(wave), .o_timer_pulse_pin(pins),
    .o_channel_rst_n(crst), .o_clock_run(crun), .o_count_tick(ctick), .o_trigger(trig),
    .o_mode(mode), .o_mode_error(merr), .o_prescale_select(psel), .o_slave_mode(slv));
  tmoc_pin_far u_tmoc_pin_far (.i_mclk(clk), .i_step(tog), .o_tin(tin));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    ticks <= ticks + ctick;
    trigs <= trigs + trig;
  end
  function automatic logic [1:0] pexp(input logic [3:0] c, input logic [1:0] v);
    pexp[0] = c[0] ? v[0] ^ c[1] : c[1];
    pexp[1] = c[2] ? v[1] ^ c[3] : c[3];
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task w(input logic [27:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task r(input logic [27:0] a, input logic [7:0] e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  task idle(input int k);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  task tg(input int k);
    repeat (k) begin
      tog <= 1'b1;
      @(posedge clk);
      tog <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    b = $urandom(32'ha948);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    r(RA, 8'h00);
    r(MA, 8'h00);
    r(OA, 8'h00);
    w(MA, 8'hff);
    w(OA, 8'hff);
    w(28'h000_0123, 8'hff);
    r(MA, 8'ha7);
    chk({7'h0, merr}, 8'h01);
    r(OA, 8'h0f);
    r(28'h000_0123, 8'h00);
    $display("register test done");
    for (int m = 0; m < 7; m++) begin
      w(RA, 8'h00);
      w(MA, 8'(m));
      r(MA, 8'(m));
      chk({5'h0, mode}, 8'(m));
      chk({7'h0, merr}, 8'h00);
      g0 = trigs;
      w(MA, 8'(m) | 8'h40);
      b = $urandom % 8;
      w(RA, 8'h80 | 8'(b));
      idle(3);
      #1 chk({6'h0, crst, crun}, 8'h03);
      chk({5'h0, psel}, 8'(b));
      r(RA, 8'h80 | 8'(b));
      w(MA, 8'(m) | 8'h40);
      idle(3);
      chk(8'(trigs - g0), (m == 2 || m == 3) ? 8'h01 : 8'h00);
    end
    $display("mode and soft trigger test done");
    foreach (cfg[k]) for (int i = 0; i < 4; i++) begin
      w(RA, 8'h00);
      ees <= 2'(i);
      tes <= 2'(i);
      w(MA, cfg[k]);
      w(RA, 8'h80);
      idle(3);
      t0 = ticks;
      g0 = trigs;
      tg(4);
      idle(6);
      n = (i == 3) ? 4 : (i == 0 ? 0 : 2);
      chk(8'(ticks - t0), cfg[k] == 8'h02 ? 8'h00 : 8'(n));
      chk(8'(trigs - g0), cfg[k] == 8'h02 ? 8'(n) : 8'h00);
    end
    w(RA, 8'h00);
    w(MA, 8'h00);
    w(RA, 8'h80);
    idle(3);
    t0 = ticks;
    n = 0;
    repeat (20) begin
      b = $urandom % 2;
      tick <= 1'(b);
      n += b;
      @(posedge clk);
    end
    tick <= 1'b0;
    idle(4);
    chk(8'(ticks - t0), 8'(n));
    $display("edge and count test done");
    w(RA, 8'h00);
    repeat (16) begin
      o = 8'($urandom);
      wave <= 2'($urandom);
      w(OA, o);
      idle(2);
      #1 chk({6'h0, pins}, {6'h0, pexp(o[3:0], wave)});
    end
    $display("pin test done");
    w(MA, 8'h80);
    w(RA, 8'h80);
    r(RA, 8'h00);
    mrun <= 1'b1;
    idle(3);
    #1 chk({6'h0, slv, crun}, 8'h03);
    mrun <= 1'b0;
    w(MA, 8'h00);
    idle(3);
    chk({7'h0, crun}, 8'h00);
    $display("slave test done");
    give_verdict();
  end
endmodule
